// ==== rtl/rbp_pkg.sv ====
// Package of constants and types for the reset, boot, power and clock divider block.
package rbp_pkg;

  // SFR addresses.
  localparam logic [7:0] RBP_ADDR_PWR   = 8'h87;
  localparam logic [7:0] RBP_ADDR_CDIV  = 8'h97;
  localparam logic [7:0] RBP_ADDR_FBOOT = 8'hC7;

  // Power control field positions.
  localparam int RBP_PWR_SLEEP_BIT = 0;
  localparam int RBP_PWR_STOP_BIT  = 1;
  localparam int RBP_PWR_GF0_BIT   = 2;
  localparam int RBP_PWR_GF1_BIT   = 3;
  localparam int RBP_PWR_SUP_BIT   = 4;

  // Flash boot control field positions.
  localparam int RBP_FB_SOFT_RESET_TRIGGER_BIT = 5;
  localparam int RBP_FB_BOOT_BIT  = 6;

  // Clock divide code field.
  localparam int RBP_CDIV_LSB = 0;
  localparam int RBP_CDIV_W   = 3;

  // Reset values.
  localparam logic [7:0] RBP_PWR_RST   = 8'h10;
  localparam logic [7:0] RBP_CDIV_RST  = 8'h00;
  localparam logic [7:0] RBP_FBOOT_RST = 8'h40;

  // Restart address and reset pulse length in system clock cycles.
  localparam logic [15:0] RBP_RESTART_ADDR = 16'h0000;
  localparam int          RBP_RST_PULSE    = 4;

  // Wake-up settle count in master clocks.
  localparam int RBP_WAKE_COUNT = 32768;

  typedef enum logic [2:0] {
    RBP_RUN,
    RBP_IDLE,
    RBP_STOP,
    RBP_SETTLE,
    RBP_RESET
  } rbp_mode_e;

endpackage : rbp_pkg

// ==== rtl/rbp_div_if.sv ====
// Interface carrying the divide code and the system clock enable.
`timescale 1ns/100ps
interface rbp_div_if;
  logic [2:0] divCode;
  logic       run;
  logic       sysEn;
  modport ctrl (output divCode, output run, input sysEn);
  modport div  (input divCode, input run, output sysEn);
endinterface : rbp_div_if

// ==== rtl/rbp_clk_div.sv ====
// Power-of-two divider producing the system clock enable.
`timescale 1ns/100ps
module rbp_clk_div
  import rbp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Divider port
  rbp_div_if.div   dv
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       en;
  } rbp_div_s;

  rbp_div_s st_r;
  rbp_div_s st_nxt;

  function automatic logic [6:0] divMask(input logic [2:0] code);
    divMask = 7'(({7'h00, 1'b1} << code) - 8'h01);
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.en = 1'b0;
    // The counter is masked by the current code, so a downward code change causes no long wrap.
    if (!dv.run) begin
      st_nxt.cnt = 7'h00;
    end else if ((st_r.cnt & divMask(dv.divCode)) == divMask(dv.divCode)) begin
      st_nxt.cnt = 7'h00;
      st_nxt.en  = 1'b1;
    end else begin
      st_nxt.cnt = 7'((st_r.cnt + 7'h01) & divMask(dv.divCode));
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dv.sysEn = st_r.en;

endmodule : rbp_clk_div

// ==== rtl/rbp_top.sv ====
// Reset source, boot area, low-power mode and clock divider controller.
`timescale 1ns/100ps
module rbp_top
  import rbp_pkg::*;
#(
  parameter int WAKE_COUNT = RBP_WAKE_COUNT
) (
  // Clock and resets
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        coldPowerUp,
  input  wire logic        resetPinEvt,
  input  wire logic        watchdogEvt,
  input  wire logic        badAddrEvt,
  input  wire logic        lowVoltEvt,
  // SFR access
  input  wire logic [7:0]  sfrAddr,
  input  wire logic [7:0]  sfrWdata,
  input  wire logic        sfrWr,
  input  wire logic        sfrRd,
  output logic      [7:0]  sfrRdata,
  // Loader status
  input  wire logic        loaderNoCommand,
  // Wake-up sources
  input  wire logic [4:0]  extIntPin,
  input  wire logic [5:0]  capturePin,
  input  wire logic [3:0]  serialRxPin,
  input  wire logic [4:0]  timerCountPin,
  input  wire logic        wakeTimerEvt,
  input  wire logic        extIrq,
  input  wire logic        timerIrq,
  input  wire logic        lowVoltIrq,
  input  wire logic        adcIrq,
  input  wire logic        anyEnabledIrq,
  // Clock and reset outputs
  output logic             oscRun,
  output logic             periphClkEn,
  output logic             cpuClkEn,
  output logic             sysReset,
  output logic             bootLoader,
  output logic      [15:0] restartAddr
);

  ////////////////////////////////////////////////////////////////////////////
  // Notes for users of this block.
  //
  // Reset causes arrive as event inputs. The watchdog, the address checker and the
  // supply monitor that raise them live elsewhere.
  // Outside deep stop and settle, events, interrupts and register accesses are taken on
  // divider ticks only. At a slow divide code a source must hold its request until a
  // tick has passed, or the request is lost. This keeps those decisions on the slowed clock.
  // Deep stop and the settle count run on every master clock. The divider is held
  // while the oscillator is off, and the settle time is counted in master clocks.
  // The restart address is always zero. Only the boot area select tells the fetch
  // unit which memory to map at that address.
  // The upper bits of the divide register are stored and read back but drive
  // nothing here. Other blocks that share the register read those bits themselves.
  // A soft reset write that arrives together with a hardware reset event is dropped.
  // The hardware event already restarts the core, so nothing is lost.

  // All state except the divider's own counter sits in one record behind one gated register. That gate is what
  // makes the divide code reach every other clocked circuit of the block outside deep stop and settle.
  typedef struct packed {
    // Operating mode and the registers that software sees.
    rbp_mode_e  mode;
    logic [7:0] pwr;
    logic [7:0] cdiv;
    logic       boot;
    // Counters for the reset pulse and the wake-up settle time.
    logic [2:0] rstCnt;
    logic [15:0] wakeCnt;
    // Registered copies of everything that leaves the block except the constant restart address.
    logic [7:0] rdata;
    logic       osc;
    logic       pEn;
    logic       cEn;
    logic       sRst;
    logic       bootOut;
    // Kept clear; wake pins act on level, so no history is needed.
    logic [5:0] pinPrev;
  } rbp_state_s;

  rbp_state_s st_r;
  rbp_state_s st_nxt;
  rbp_div_if  divBus ();

  rbp_clk_div u_div (
    .core_clk (core_clk),
    .rst      (rst),
    .dv       (divBus.div)
  );

  assign divBus.divCode = st_r.cdiv[RBP_CDIV_LSB +: RBP_CDIV_W];
  assign divBus.run     = st_r.osc;

  function automatic logic wrHit(input logic [7:0] a, input logic [7:0] target, input logic w);
    wrHit = w && (a == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wake qualifiers.

  logic stopWake;
  logic idleWake;
  logic pinWake;
  // Any wake pin acts on its level. A pin that is still high when deep stop is
  // entered wakes the block again at once, so software should clear it first.
  // The wake-up timer counts as a pin for the settle rule.
  assign pinWake  = |{extIntPin, capturePin, serialRxPin, timerCountPin};
  assign stopWake = pinWake || wakeTimerEvt;
  assign idleWake = extIrq || timerIrq || lowVoltIrq || adcIrq || anyEnabledIrq;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic       startReset;
    logic       nextBoot;
    logic [7:0] fbRead;
    startReset = 1'b0;
    nextBoot   = st_r.boot;
    fbRead     = 8'h00;
    st_nxt = st_r;
    st_nxt.pinPrev = 6'h00;

    // Reset sources; pin and power-up force loader, watchdog/address/supply keep the bit, soft reset writes it, loaderNoCommand clears it.
    if (coldPowerUp) begin
      startReset = 1'b1;
      nextBoot   = 1'b1;
      st_nxt.pwr[RBP_PWR_SUP_BIT] = 1'b1;
    end else if (resetPinEvt) begin
      startReset = 1'b1;
      nextBoot   = 1'b1;
    end else if (watchdogEvt || badAddrEvt || lowVoltEvt) begin
      startReset = 1'b1;
    end else if (wrHit(sfrAddr, RBP_ADDR_FBOOT, sfrWr) && sfrWdata[RBP_FB_SOFT_RESET_TRIGGER_BIT]) begin
      startReset = 1'b1;
      nextBoot   = sfrWdata[RBP_FB_BOOT_BIT];
    end else if (st_r.boot && loaderNoCommand && st_r.mode == RBP_RUN) begin
      startReset = 1'b1;
      nextBoot   = 1'b0;
    end else if (sfrWr && st_r.mode == RBP_RUN) begin
      case (sfrAddr)
        RBP_ADDR_PWR: begin
          // Supply-up flag only clears or stays; software cannot raise it.
          st_nxt.pwr[3:0] = sfrWdata[3:0];
          st_nxt.pwr[RBP_PWR_SUP_BIT] = st_r.pwr[RBP_PWR_SUP_BIT] & sfrWdata[RBP_PWR_SUP_BIT];
          if (sfrWdata[RBP_PWR_STOP_BIT]) begin
            st_nxt.mode = RBP_STOP;
          end else if (sfrWdata[RBP_PWR_SLEEP_BIT]) begin
            st_nxt.mode = RBP_IDLE;
          end
        end
        RBP_ADDR_CDIV: st_nxt.cdiv = sfrWdata;
        RBP_ADDR_FBOOT: nextBoot = sfrWdata[RBP_FB_BOOT_BIT];
        default: ;
      endcase
    end

    if (startReset) begin
      st_nxt.mode   = RBP_RESET;
      st_nxt.rstCnt = 3'(RBP_RST_PULSE - 1);
      st_nxt.pwr[RBP_PWR_STOP_BIT]  = 1'b0;
      st_nxt.pwr[RBP_PWR_SLEEP_BIT] = 1'b0;
    end
    st_nxt.boot = nextBoot;

    if (!startReset) begin
      case (st_r.mode)
        // Running: only software writes, reset events and loaderNoCommand move the mode.
        RBP_RUN: ;
        // Idle: peripherals keep their clock, the CPU waits for an interrupt.
        RBP_IDLE: begin
          if (idleWake) begin
            st_nxt.mode = RBP_RUN;
            st_nxt.pwr[RBP_PWR_SLEEP_BIT] = 1'b0;
          end
        end
        // Deep stop: the oscillator is off, only the wake inputs and the reset sources are watched.
        RBP_STOP: begin
          if (stopWake) begin
            st_nxt.mode    = RBP_SETTLE;
            st_nxt.wakeCnt = 16'(WAKE_COUNT - 1);
          end
        end
        // Settle: the oscillator runs again but the CPU clock stays held so
        // that an unsteady clock never reaches it.
        RBP_SETTLE: begin
          if (st_r.wakeCnt == 16'h0000) begin
            st_nxt.mode = RBP_RUN;
            st_nxt.pwr[RBP_PWR_STOP_BIT]  = 1'b0;
            st_nxt.pwr[RBP_PWR_SLEEP_BIT] = 1'b0;
          end else begin
            st_nxt.wakeCnt = st_r.wakeCnt - 16'h0001;
          end
        end
        // Reset pulse: counted in ticks, so it stretches with the divide code.
        RBP_RESET: begin
          if (st_r.rstCnt == 3'h0) begin
            st_nxt.mode = RBP_RUN;
          end else begin
            st_nxt.rstCnt = st_r.rstCnt - 3'h1;
          end
        end
        default: st_nxt.mode = RBP_RESET;
      endcase
    end

    // Outputs are registered copies of the mode decode and the boot bit.
    st_nxt.osc  = (st_nxt.mode != RBP_STOP);
    st_nxt.pEn  = st_nxt.osc;
    st_nxt.cEn  = (st_nxt.mode == RBP_RUN);
    st_nxt.sRst = (st_nxt.mode == RBP_RESET);
    st_nxt.bootOut = st_nxt.boot;

    //////////////////////////////////////////////////////////////////////////
    // Read data.

    // Soft reset trigger always reads 0 because it self-clears.
    // Read data are cleared on ticks without a read, so a stale value never
    // looks like a fresh answer.
    fbRead = 8'h00;
    fbRead[RBP_FB_BOOT_BIT] = st_r.boot;
    st_nxt.rdata = 8'h00;
    if (sfrRd) begin
      case (sfrAddr)
        RBP_ADDR_PWR:   st_nxt.rdata = st_r.pwr;
        RBP_ADDR_CDIV:  st_nxt.rdata = st_r.cdiv;
        RBP_ADDR_FBOOT: st_nxt.rdata = fbRead;
        default:        st_nxt.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // The register loads only on divider ticks, except while the oscillator is off
  // or settling. Those states count master clocks and must not wait for a tick,
  // because the divider itself is held while the oscillator is stopped.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r         <= '0;
      st_r.mode    <= RBP_RESET;
      st_r.pwr     <= RBP_PWR_RST;
      st_r.cdiv    <= RBP_CDIV_RST;
      st_r.boot    <= RBP_FBOOT_RST[RBP_FB_BOOT_BIT];
      st_r.rstCnt  <= 3'(RBP_RST_PULSE - 1);
      st_r.osc     <= 1'b1;
      st_r.pEn     <= 1'b1;
      st_r.sRst    <= 1'b1;
      st_r.bootOut <= 1'b1;
    end else if (divBus.sysEn || !st_r.osc || st_r.mode == RBP_SETTLE) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each taken straight from the state register except the constant restart address.

  assign sfrRdata    = st_r.rdata;
  assign oscRun      = st_r.osc;
  assign periphClkEn = st_r.pEn;
  assign cpuClkEn    = st_r.cEn;
  assign sysReset    = st_r.sRst;
  assign bootLoader  = st_r.bootOut;
  assign restartAddr = RBP_RESTART_ADDR;

endmodule : rbp_top

// ==== tb/rbp_top_properties.sv ====
// Concurrent checks on the ports of the reset, boot, power and divider block.
`timescale 1ns/100ps
module rbp_top_chk
  import rbp_pkg::*;
#(
  parameter int WAKE_COUNT = RBP_WAKE_COUNT
) (
  // Clock, reset events and the interrupt that ends idle
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        coldPowerUp,
  input wire logic        resetPinEvt,
  input wire logic        anyEnabledIrq,
  // Observed outputs
  input wire logic        oscRun,
  input wire logic        periphClkEn,
  input wire logic        cpuClkEn,
  input wire logic        sysReset,
  input wire logic        bootLoader,
  input wire logic [15:0] restartAddr
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // The settle span below is written for the bench value of WAKE_COUNT, 8.
  a_reset_gates_cpu: assert property (sysReset |-> !cpuClkEn)
    else $error("cpu clock enabled during reset pulse");
  a_reset_pulse_len: assert property ($rose(sysReset) |-> sysReset[*4])
    else $error("reset pulse shorter than four cycles");
  a_restart_addr_zero: assert property (restartAddr == 16'h0000)
    else $error("restart address not zero");
  a_pin_to_loader: assert property (resetPinEvt |-> ##[1:600] (sysReset && bootLoader))
    else $error("pin reset did not select loader");
  a_cold_to_loader: assert property (coldPowerUp |-> ##[1:600] (sysReset && bootLoader))
    else $error("cold reset did not select loader");
  a_warm_keeps_boot: assert property (sysReset && $past(sysReset) && !$past(coldPowerUp)
    && !$past(resetPinEvt) |-> $stable(bootLoader)) else $error("boot select moved in reset");
  a_stop_gates_all: assert property (!oscRun |-> !cpuClkEn && !periphClkEn)
    else $error("clock enabled while oscillator stopped");
  a_settle_holds_cpu: assert property ($rose(oscRun) |-> !cpuClkEn[*8])
    else $error("cpu clock released before settle count");
  a_idle_irq_exit: assert property (!cpuClkEn && oscRun && !sysReset && anyEnabledIrq
    |-> ##[1:300] cpuClkEn) else $error("idle not left on interrupt");
endmodule // rbp_top_chk

bind rbp_top rbp_top_chk #(.WAKE_COUNT(WAKE_COUNT)) u_rbp_top_chk (
  .core_clk, .rst, .coldPowerUp, .resetPinEvt, .anyEnabledIrq, .oscRun,
  .periphClkEn, .cpuClkEn, .sysReset, .bootLoader, .restartAddr);

// ==== tb/test_rbp_top.sv ====
// Self-checking bench for the reset, boot, power and divider block.
`timescale 1ns/100ps
module test_rbp_top;
  import rbp_pkg::*;
  logic        core_clk = 0;
  logic        rst      = 1;
  logic [4:0]  evt      = '0;
  logic [20:0] wake     = '0;
  logic [4:0]  irq      = '0;
  logic [7:0]  sfrAddr  = '0;
  logic [7:0]  sfrWdata = '0;
  logic        sfrWr    = 0;
  logic        sfrRd    = 0;
  logic        loaderNoCommand = 0;
  logic [7:0]  sfrRdata;
  logic [15:0] restartAddr;
  logic        oscRun, periphClkEn, cpuClkEn, sysReset, bootLoader;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          span        = 1;
  int          hiRun       = 0;
  int          hiLast      = 0;
  int          w;
  // Rows: write flag, address, write data, expected read.
  logic [24:0] rows [9] = '{{1'b0, 24'h870010}, {1'b0, 24'h970000}, {1'b0, 24'hC70040},
    {1'b1, 24'h870C0C}, {1'b1, 24'h871000}, {1'b1, 24'h97F8F8}, {1'b1, 24'h55AA00},
    {1'b1, 24'hC74040}, {1'b1, 24'hC70000}};

  rbp_top #(.WAKE_COUNT(8)) u_rbp_top (
    .core_clk, .rst, .coldPowerUp(evt[0]), .resetPinEvt(evt[1]), .watchdogEvt(evt[2]),
    .badAddrEvt(evt[3]), .lowVoltEvt(evt[4]), .sfrAddr, .sfrWdata, .sfrWr, .sfrRd,
    .sfrRdata, .loaderNoCommand, .extIntPin(wake[4:0]), .capturePin(wake[10:5]),
    .serialRxPin(wake[14:11]), .timerCountPin(wake[19:15]), .wakeTimerEvt(wake[20]),
    .extIrq(irq[0]), .timerIrq(irq[1]), .lowVoltIrq(irq[2]), .adcIrq(irq[3]),
    .anyEnabledIrq(irq[4]), .oscRun, .periphClkEn, .cpuClkEn, .sysReset, .bootLoader,
    .restartAddr);

  initial forever #5 core_clk = ~core_clk;
  // Counts the clock edges over which the reset pulse stood, however it began.
  always @(posedge core_clk) begin
    if (sysReset === 1'b1) begin
      hiRun <= hiRun + 1;
    end else if (hiRun != 0) begin
      hiLast <= hiRun;
      hiRun  <= 0;
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Holding for one full divide period makes exactly one tick take the access.
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic wr);
    @(posedge core_clk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWr <= wr;
    sfrRd <= !wr;
    repeat (span) @(posedge core_clk);
    sfrWr <= 0;
    sfrRd <= 0;
    #1;
  endtask
  task automatic rwait(output int hi);
    int n;
    n = 0;
    hi = 0;
    while (!sysReset && n < 999) begin @(posedge core_clk); #1; n++; end
    while (sysReset && n < 999) begin @(posedge core_clk); #1; n++; end
    @(posedge core_clk);
    #1;
    hi = hiLast;
  endtask
  task automatic cwait(output int n);
    n = 0;
    while (!cpuClkEn && n < 999) begin @(posedge core_clk); #1; n++; end
    #1;
  endtask
  task automatic pulse(input int i, input logic expBoot);
    int hi;
    @(posedge core_clk);
    evt[i] <= 1;
    @(posedge core_clk);
    evt[i] <= 0;
    rwait(hi);
    chk(bootLoader, expBoot, "boot");
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 0;
    cwait(w);
    chk(bootLoader, 1, "boot");
    chk(restartAddr, 16'h0000, "addr");
    foreach (rows[i]) begin
      if (rows[i][24]) acc(rows[i][23:16], rows[i][15:8], 1);
      acc(rows[i][23:16], 8'h00, 0);
      chk(sfrRdata, rows[i][7:0], "reg");
    end
    acc(RBP_ADDR_FBOOT, 8'h60, 1);
    rwait(w);
    chk(bootLoader, 1, "boot");
    acc(RBP_ADDR_FBOOT, 8'h00, 0);
    chk(sfrRdata, 8'h40, "trigger");
    acc(RBP_ADDR_FBOOT, 8'h20, 1);
    rwait(w);
    chk(w, 4, "pulse");
    chk(bootLoader, 0, "boot");
    for (int i = 2; i < 5; i++) begin
      acc(RBP_ADDR_FBOOT, 8'h40, 1);
      pulse(i, 1);
      acc(RBP_ADDR_FBOOT, 8'h00, 1);
      pulse(i, 0);
    end
    pulse(1, 1);
    acc(RBP_ADDR_FBOOT, 8'h00, 1);
    pulse(0, 1);
    acc(RBP_ADDR_PWR, 8'h00, 0);
    chk(sfrRdata[4], 1, "supply");
    @(posedge core_clk);
    loaderNoCommand <= 1;
    rwait(w);
    chk(bootLoader, 0, "boot");
    loaderNoCommand <= 0;
    acc(RBP_ADDR_CDIV, 8'h02, 1);
    span = 4;
    acc(RBP_ADDR_FBOOT, 8'h20, 1);
    rwait(w);
    chk(w, 16, "slow pulse");
    acc(RBP_ADDR_CDIV, 8'h00, 1);
    span = 1;
    for (int i = 0; i < 21; i++) begin
      acc(RBP_ADDR_PWR, i[0] ? 8'h03 : 8'h02, 1);
      repeat (2) @(posedge core_clk);
      #1;
      chk({oscRun, periphClkEn, cpuClkEn}, 0, "stop");
      @(posedge core_clk);
      wake[i] <= 1;
      @(posedge core_clk);
      wake[i] <= 0;
      cwait(w);
      chk(cpuClkEn && w > 6, 1, "wake");
    end
    acc(RBP_ADDR_CDIV, 8'h01, 1);
    span = 2;
    for (int i = 0; i < 5; i++) begin
      acc(RBP_ADDR_PWR, 8'h01, 1);
      repeat (2) @(posedge core_clk);
      #1;
      chk({periphClkEn, cpuClkEn}, 2'b10, "idle");
      @(posedge core_clk);
      irq[i] <= 1;
      repeat (2) @(posedge core_clk);
      irq[i] <= 0;
      cwait(w);
      acc(RBP_ADDR_PWR, 8'h00, 0);
      chk(sfrRdata[0], 0, "sleep bit");
    end
    end_of_test;
  end

  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end
endmodule // test_rbp_top
